/* File: charger_interrupt_mask_bank.sv */
// module: interrupt mask bank top with top-off flag and interrupt pin drive
// ------------------------------------------------------------------
// Functional notes
// - mask bit 7 blocks input validation failure
// - mask bit 6 blocks secondary input change
// - mask bit 5 blocks bus input change
// - mask bit 4 blocks low battery threshold
// - mask bit 3 blocks charge done
// - mask bit 2 blocks charge phase change
// - mask bit 1 blocks weak battery
// - mask bit 0 blocks battery event
// - second mask bit 7 blocks termination crossing
// - second mask bit 6 blocks recharge threshold
// - second mask bit 5 blocks boost overvoltage
// - second mask bit 4 blocks boost thermal shutdown
// - second mask bit 3 blocks boost startup failure
// - second mask bit 0 blocks boost low battery
// - third mask bit 7 blocks top-off complete
// - top-off timer expiry sets flag when termination and top-off are both enabled; read clears unless a set lands on the same edge
// ------------------------------------------------------------------
`timescale 1ns/1ps
module charger_interrupt_mask_bank
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic [7:0] input_charge_flags,
  input wire logic [7:0] boost_current_flags,
  input wire logic [6:0] fault_other_flags,
  input wire logic topoff_timer_expired,
  input wire logic term_enable,
  input wire logic topoff_enable,
  output logic int_o,
  output logic int_oe
);

  // ------------------------------------------------------------------
  // register command carrier and mask registers
  // ------------------------------------------------------------------
  mask_reg_if cmd_if ();

  logic [7:0] input_charge_event_masks;
  logic [7:0] boost_current_event_masks;
  logic [7:0] fault_event_masks;

  // writes reach the mask registers unchanged
  assign cmd_if.cmd.addr = reg_addr;
  assign cmd_if.cmd.wdata = reg_wdata;
  assign cmd_if.cmd.wr = reg_wr;

  mask_byte_reg #(
    .reg_addr(mask_bank_pkg::input_charge_event_masks_addr),
    .writable(mask_bank_pkg::all_bits_writable)
  ) u_input_charge_masks (
    .clock(clock),
    .nrst(nrst),
    .bus(cmd_if.sink),
    .value(input_charge_event_masks)
  );

  // bit 1 is reserved: never stored, so it reads back zero
  mask_byte_reg #(
    .reg_addr(mask_bank_pkg::boost_current_event_masks_addr),
    .writable(mask_bank_pkg::boost_current_writable)
  ) u_boost_current_masks (
    .clock(clock),
    .nrst(nrst),
    .bus(cmd_if.sink),
    .value(boost_current_event_masks)
  );

  mask_byte_reg #(
    .reg_addr(mask_bank_pkg::fault_event_masks_addr),
    .writable(mask_bank_pkg::all_bits_writable)
  ) u_fault_masks (
    .clock(clock),
    .nrst(nrst),
    .bus(cmd_if.sink),
    .value(fault_event_masks)
  );

  // ------------------------------------------------------------------
  // named mask fields
  // ------------------------------------------------------------------
  logic mask_input_validation_fail;
  logic mask_secondary_input_change;
  logic mask_bus_input_change;
  logic mask_low_battery_threshold;
  logic mask_charge_done;
  logic mask_charge_phase_change;
  logic mask_weak_battery;
  logic mask_battery_event;
  logic mask_term_current_cross;
  logic mask_recharge_threshold;
  logic mask_boost_overvoltage;
  logic mask_boost_thermal_shutdown;
  logic mask_boost_startup_fail;
  logic mask_boost_battery_undervoltage;
  logic mask_boost_low_battery;
  logic mask_topoff_complete;

  // field decode of the three mask registers
  assign mask_input_validation_fail = input_charge_event_masks[7];
  assign mask_secondary_input_change = input_charge_event_masks[6];
  assign mask_bus_input_change = input_charge_event_masks[5];
  assign mask_low_battery_threshold = input_charge_event_masks[4];
  assign mask_charge_done = input_charge_event_masks[3];
  assign mask_charge_phase_change = input_charge_event_masks[2];
  assign mask_weak_battery = input_charge_event_masks[1];
  assign mask_battery_event = input_charge_event_masks[0];
  assign mask_term_current_cross = boost_current_event_masks[7];
  assign mask_recharge_threshold = boost_current_event_masks[6];
  assign mask_boost_overvoltage = boost_current_event_masks[5];
  assign mask_boost_thermal_shutdown = boost_current_event_masks[4];
  assign mask_boost_startup_fail = boost_current_event_masks[3];
  assign mask_boost_battery_undervoltage = boost_current_event_masks[2];
  assign mask_boost_low_battery = boost_current_event_masks[0];
  assign mask_topoff_complete = fault_event_masks[mask_bank_pkg::topoff_complete_bit];

  // ------------------------------------------------------------------
  // top-off complete flag
  // ------------------------------------------------------------------
  logic topoff_complete_flag_q;
  logic topoff_complete_flag_d;
  logic topoff_set;
  logic fault_read;

  // set needs both termination and top-off enabled; a set beats a read clear
  assign topoff_set = topoff_timer_expired && term_enable && topoff_enable;
  assign fault_read = reg_rd && (reg_addr == mask_bank_pkg::fault_flags_addr);
  assign topoff_complete_flag_d = topoff_set ? 1'b1 :
                                  (fault_read ? 1'b0 : topoff_complete_flag_q);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      topoff_complete_flag_q <= 1'b0;
    else
      topoff_complete_flag_q <= topoff_complete_flag_d;
  end

  // ------------------------------------------------------------------
  // flag gating and interrupt drive
  // ------------------------------------------------------------------
  logic [7:0] fault_flags;
  logic [7:0] input_masks_used;
  logic [7:0] boost_masks_used;
  logic [7:0] fault_masks_used;
  logic [7:0] boost_flags_used;
  logic any_input;
  logic any_boost;
  logic any_fault;
  logic int_low_q;
  logic int_low_d;

  // the boost watchdog flag at bit 1 has no mask here and is not gated in
  assign boost_flags_used = boost_current_flags & mask_bank_pkg::boost_current_writable;
  assign fault_flags = {topoff_complete_flag_q, fault_other_flags};

  // gate masks rebuilt from the named fields, fault bits 6:0 taken straight from the register; the unmaskable boost slot stays open
  assign input_masks_used = {mask_input_validation_fail, mask_secondary_input_change,
                             mask_bus_input_change, mask_low_battery_threshold,
                             mask_charge_done, mask_charge_phase_change,
                             mask_weak_battery, mask_battery_event};
  assign boost_masks_used = {mask_term_current_cross, mask_recharge_threshold,
                             mask_boost_overvoltage, mask_boost_thermal_shutdown,
                             mask_boost_startup_fail, mask_boost_battery_undervoltage,
                             1'b0, mask_boost_low_battery};
  assign fault_masks_used = {mask_topoff_complete, fault_event_masks[6:0]};

  event_gate u_gate_input (
    .flags(input_charge_flags),
    .masks(input_masks_used),
    .pending(),
    .any(any_input)
  );

  event_gate u_gate_boost (
    .flags(boost_flags_used),
    .masks(boost_masks_used),
    .pending(),
    .any(any_boost)
  );

  event_gate u_gate_fault (
    .flags(fault_flags),
    .masks(fault_masks_used),
    .pending(),
    .any(any_fault)
  );

  // pin is pulled low while any unmasked flag other than boost bit 1 stands, released otherwise
  assign int_low_d = any_input || any_boost || any_fault;
  assign int_o = 1'b0; // open drain: only ever pulls low
  assign int_oe = int_low_q;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      int_low_q <= 1'b0;
    else
      int_low_q <= int_low_d;
  end

  // ------------------------------------------------------------------
  // register read path
  // ------------------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic hit_q;
  logic hit_d;
  logic [7:0] read_mux;
  logic addr_known;

  // fault flag register: only the top-off bit lives here, others read zero
  assign read_mux = (reg_addr == mask_bank_pkg::input_charge_event_masks_addr) ?
                      input_charge_event_masks :
                    (reg_addr == mask_bank_pkg::boost_current_event_masks_addr) ?
                      boost_current_event_masks :
                    (reg_addr == mask_bank_pkg::fault_event_masks_addr) ?
                      fault_event_masks :
                    (reg_addr == mask_bank_pkg::fault_flags_addr) ?
                      {topoff_complete_flag_q, 7'h00} : 8'h00;
  assign addr_known = (reg_addr == mask_bank_pkg::input_charge_event_masks_addr) ||
                      (reg_addr == mask_bank_pkg::boost_current_event_masks_addr) ||
                      (reg_addr == mask_bank_pkg::fault_event_masks_addr) ||
                      (reg_addr == mask_bank_pkg::fault_flags_addr);
  assign rdata_d = reg_rd ? read_mux : rdata_q;
  assign hit_d = reg_rd ? addr_known : hit_q;
  assign reg_rdata = rdata_q;
  assign reg_hit = hit_q;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_q <= 8'h00;
      hit_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      hit_q <= hit_d;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_int_follows_pending: assert property (@(posedge clock) disable iff (!nrst)
    (any_input || any_boost || any_fault) |=> int_oe)
    else $error("interrupt not pulled low for a pending flag");

  a_int_released_idle: assert property (@(posedge clock) disable iff (!nrst)
    !(any_input || any_boost || any_fault) |=> !int_oe)
    else $error("interrupt held low with nothing pending");

  a_input_validation_fail_flag_masked: assert property (@(posedge clock) disable iff (!nrst)
    (input_charge_flags == 8'h80 && mask_input_validation_fail && !any_boost && !any_fault)
    |=> !int_oe)
    else $error("masked validation failure drove the interrupt");

  a_battery_unmasked: assert property (@(posedge clock) disable iff (!nrst)
    (input_charge_flags[0] && !mask_battery_event) |=> int_oe)
    else $error("unmasked battery event missed the interrupt");

  a_boost_low_masked: assert property (@(posedge clock) disable iff (!nrst)
    (boost_current_flags == 8'h01 && mask_boost_low_battery && !any_input && !any_fault)
    |=> !int_oe)
    else $error("masked boost low battery drove the interrupt");

  a_reserved_reads_zero: assert property (@(posedge clock) disable iff (!nrst)
    (reg_rd && reg_addr == mask_bank_pkg::boost_current_event_masks_addr)
    |=> !reg_rdata[mask_bank_pkg::reserved_boost_bit])
    else $error("reserved mask bit read back as one");

  a_topoff_sets: assert property (@(posedge clock) disable iff (!nrst)
    (topoff_timer_expired && term_enable && topoff_enable) |=> topoff_complete_flag_q)
    else $error("top-off flag not set on timer expiry");

  a_topoff_read_clears: assert property (@(posedge clock) disable iff (!nrst)
    (fault_read && !topoff_set) |=> !topoff_complete_flag_q)
    else $error("top-off flag survived its read");

  a_topoff_masked: assert property (@(posedge clock) disable iff (!nrst)
    (mask_topoff_complete && topoff_complete_flag_q && fault_other_flags == 7'h00
     && !any_input && !any_boost) |=> !int_oe)
    else $error("masked top-off flag drove the interrupt");

  a_mask_write_lands: assert property (@(posedge clock) disable iff (!nrst)
    (reg_wr && reg_addr == mask_bank_pkg::boost_current_event_masks_addr)
    |=> (mask_term_current_cross == $past(reg_wdata[7])))
    else $error("mask write did not land");

endmodule

/* File: mask_bank_pkg.sv */
// package: register map, field positions and reset values of the interrupt mask bank
package mask_bank_pkg;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] fault_flags_addr = 8'h06;
  localparam logic [7:0] input_charge_event_masks_addr = 8'h08;
  localparam logic [7:0] boost_current_event_masks_addr = 8'h09;
  localparam logic [7:0] fault_event_masks_addr = 8'h0a;

  // ------------------------------------------------------------------
  // reset values and writable bits
  // ------------------------------------------------------------------
  localparam logic [7:0] mask_reset = 8'h00;
  localparam logic [7:0] all_bits_writable = 8'hff;
  localparam logic [7:0] boost_current_writable = 8'hfd;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int reserved_boost_bit = 1;
  localparam int topoff_complete_bit = 7;

  // register access port carried by the interface
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } reg_cmd_type;

endpackage

/* File: mask_reg_if.sv */
// interface: register write command from the bank top to its mask registers
`timescale 1ns/1ps
interface mask_reg_if;
  mask_bank_pkg::reg_cmd_type cmd;

  modport source (output cmd);
  modport sink (input cmd);
endinterface

/* File: mask_byte_reg.sv */
// module: one 8-bit mask register with per-bit write enable
`timescale 1ns/1ps
module mask_byte_reg #(
  parameter logic [7:0] reg_addr = 8'h00,
  parameter logic [7:0] writable = 8'hff
)
(
  input wire logic clock,
  input wire logic nrst,
  mask_reg_if.sink bus,
  output logic [7:0] value
);

  logic [7:0] value_q;
  logic [7:0] value_d;
  logic hit;

  // write decode: only writable bits take the new value, others stay zero
  assign hit = bus.cmd.wr && (bus.cmd.addr == reg_addr);
  assign value_d = hit ? (bus.cmd.wdata & writable) : value_q;
  assign value = value_q;

  // mask storage
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      value_q <= mask_bank_pkg::mask_reset;
    else
      value_q <= value_d;
  end

  a_readonly_bits_zero: assert property (@(posedge clock) disable iff (!nrst)
    (value_q & ~writable) == 8'h00)
    else $error("non-writable mask bit became set");

endmodule

/* File: event_gate.sv */
// module: gates one byte of event flags with its mask byte
`timescale 1ns/1ps
module event_gate
(
  input wire logic [7:0] flags,
  input wire logic [7:0] masks,
  output logic [7:0] pending,
  output logic any
);

  // a set mask bit keeps its flag from reaching the interrupt line
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_bit
      assign pending[i] = flags[i] & ~masks[i];
    end
  endgenerate

  assign any = |pending;

endmodule

/* File: host_model.sv */
// host side: pull-up on the shared active-low interrupt line
`timescale 1ns/1ps
module host_model
(
  input wire logic int_o,
  input wire logic int_oe,
  output logic int_n
);
  // the line floats high through the pull-up whenever the device lets go
  assign int_n = int_oe ? int_o : 1'b1;
endmodule

/* File: tb_charger_interrupt_mask_bank.sv */
// testbench: register access, per-bit masking and top-off flag of the mask bank
`timescale 1ns/1ps
`define chk(a, b) \
  begin \
    n_checks++; \
    if ((a) !== (b)) \
    begin \
      errors++; \
      $display("wrong value t=%0t got %h exp %h", $time, a, b); \
    end \
  end
module tb_charger_interrupt_mask_bank;
  logic clock = 0;
  logic nrst = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [7:0] reg_rdata;
  logic reg_hit;
  logic [7:0] icf = 8'h00;
  logic [7:0] bcf = 8'h00;
  logic [6:0] fof = 7'h00;
  logic tte = 0;
  logic ten = 0;
  logic toe = 0;
  logic int_o;
  logic int_oe;
  logic int_n;
  int errors = 0;
  int n_checks = 0;

  // ------------------------------------------------------------------
  // clock, design and host
  // ------------------------------------------------------------------
  initial
  begin
    forever #12.5 clock = ~clock;
  end

  charger_interrupt_mask_bank dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .input_charge_flags(icf), .boost_current_flags(bcf),
    .fault_other_flags(fof), .topoff_timer_expired(tte), .term_enable(ten),
    .topoff_enable(toe), .int_o(int_o), .int_oe(int_oe));

  host_model host (.int_o(int_o), .int_oe(int_oe), .int_n(int_n));

  // ------------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    #1;
    d = reg_rdata;
    h = reg_hit;
  endtask

  // flag inputs change together on a rising edge
  task automatic flags(input logic [7:0] i, input logic [7:0] b, input logic [6:0] f);
    @(posedge clock);
    icf <= i;
    bcf <= b;
    fof <= f;
  endtask

  // two edges: inputs land, then the registered pin follows
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask

  // one top-off timer expiry pulse with the given enables
  task automatic expire(input logic t, input logic o);
    @(posedge clock);
    ten <= t;
    toe <= o;
    tte <= 1'b1;
    @(posedge clock);
    tte <= 1'b0;
    settle();
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard well beyond the main sequence
  initial
  begin
    #500000;
    errors++;
    wrap_up();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    logic [7:0] d;
    logic h;
    logic [7:0] addrs [3];
    addrs = '{mask_bank_pkg::input_charge_event_masks_addr,
      mask_bank_pkg::boost_current_event_masks_addr, mask_bank_pkg::fault_event_masks_addr};
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    // reset values, write all ones, reserved bit
    for (int k = 0; k < 3; k++)
    begin
      rd(addrs[k], d, h);
      `chk(d, mask_bank_pkg::mask_reset)
      `chk(h, 1'b1)
      wr(addrs[k], 8'hff);
      rd(addrs[k], d, h);
      `chk(d, (k == 1) ? 8'hfd : 8'hff)
    end
    rd(8'h0b, d, h);
    `chk({d, h}, 9'h000)
    $display("test registers done");
    for (int k = 0; k < 3; k++)
      wr(addrs[k], 8'h00);
    settle();
    `chk(int_n, 1'b1)
    // each input and boost flag except boost bit 1 pulls the pin low until its own mask bit is set
    for (int i = 0; i < 8; i++)
    begin
      flags(8'h01 << i, 8'h00, 7'h00);
      settle();
      `chk(int_n, 1'b0)
      wr(addrs[0], 8'h01 << i);
      settle();
      `chk(int_n, 1'b1)
      flags(8'h00, 8'h01 << i, 7'h00);
      wr(addrs[0], 8'h00);
      settle();
      `chk(int_n, (i == 1) ? 1'b1 : 1'b0)
      wr(addrs[1], 8'h01 << i);
      settle();
      `chk(int_n, 1'b1)
      flags(8'h00, 8'h00, 7'h00);
      wr(addrs[1], 8'h00);
    end
    // remaining fault flags under the third mask byte
    flags(8'h00, 8'h00, 7'h7f);
    wr(addrs[2], 8'h7f);
    settle();
    `chk(int_n, 1'b1)
    wr(addrs[2], 8'h00);
    settle();
    `chk(int_n, 1'b0)
    flags(8'h00, 8'h00, 7'h00);
    $display("test masking done");
    // top-off flag: set, read, clear
    expire(1'b1, 1'b1);
    `chk(int_n, 1'b0)
    rd(mask_bank_pkg::fault_flags_addr, d, h);
    `chk(d, 8'h80)
    settle();
    `chk(int_n, 1'b1)
    rd(mask_bank_pkg::fault_flags_addr, d, h);
    `chk(d, 8'h00)
    // masked top-off still latches but keeps the pin high
    wr(addrs[2], 8'h80);
    expire(1'b1, 1'b1);
    `chk(int_n, 1'b1)
    rd(mask_bank_pkg::fault_flags_addr, d, h);
    `chk(d, 8'h80)
    // either enable low blocks the set
    expire(1'b0, 1'b1);
    rd(mask_bank_pkg::fault_flags_addr, d, h);
    `chk(d, 8'h00)
    expire(1'b1, 1'b0);
    rd(mask_bank_pkg::fault_flags_addr, d, h);
    `chk(d, 8'h00)
    // set and read-clear on one edge: the set wins
    @(posedge clock);
    ten <= 1'b1;
    toe <= 1'b1;
    tte <= 1'b1;
    reg_addr <= mask_bank_pkg::fault_flags_addr;
    reg_rd <= 1'b1;
    @(posedge clock);
    tte <= 1'b0;
    reg_rd <= 1'b0;
    rd(mask_bank_pkg::fault_flags_addr, d, h);
    `chk(d, 8'h80)
    `chk(h, 1'b1)
    $display("test topoff done");
    wrap_up();
  end
endmodule
